// ==== hdl/pmsu_pkg.sv ====
// Constants, state encoding and field layouts for the power management signal unit.
// Assumes a single 50 MHz clock and registers reached over APB with 32-bit data.
package pmsu_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned DEBOUNCE_MS = 16;
   localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned THR_UNIT_NS = 1000;
   localparam int unsigned THR_UNIT_CYCLES = (THR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Bus
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATE = 8'h04;
   localparam logic [7:0] REG_FSEL = 8'h08;
   localparam logic [7:0] REG_GPO = 8'h0C;
   localparam logic [7:0] REG_GPI = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_THROTTLE = 8'h18;

   // Function select bits, 1 selects the dedicated function
   localparam int FS_BATTERY_LOW_N = 0;
   localparam int FS_LID = 1;
   localparam int FS_ALERT = 2;
   localparam int FS_RI = 3;
   localparam int FS_THERMAL_DETECT_N = 4;
   localparam int FS_OUT_BASE = 5;
   localparam int FSEL_W = 12;

   // Output index, shared by function select (plus base) and general output bits
   localparam int GO_PLANE_B_SUSPEND_N = 0;
   localparam int GO_PLANE_C_SUSPEND_N = 1;
   localparam int GO_CPU = 2;
   localparam int GO_PCI = 3;
   localparam int GO_ZZ = 4;
   localparam int GO_STAT1 = 5;
   localparam int GO_STAT2 = 6;
   localparam int GPO_W = 7;

   // Synchroniser vector layout
   localparam int SY_BATTERY_LOW_N = 0;
   localparam int SY_EXT = 1;
   localparam int SY_LID = 2;
   localparam int SY_PWR = 3;
   localparam int SY_RI = 4;
   localparam int SY_ALERT = 5;
   localparam int SY_THERMAL_DETECT_N = 6;
   localparam int SY_REQ = 7;
   localparam int SYNC_W = 11;

   // Sticky status bits
   localparam int ST_EXT = 0;
   localparam int ST_LID = 1;
   localparam int ST_ALERT = 2;
   localparam int ST_PWR = 3;
   localparam int ST_RI = 4;
   localparam int ST_BLOCKED = 5;
   localparam int ST_PCI = 6;
   localparam int STS_W = 7;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [FSEL_W-1:0] FSEL_RST = 12'hFFF;
   localparam logic [GPO_W-1:0] GPO_RST = 7'h7F;
   localparam logic [7:0] THR_RST = 8'h0F;

   typedef enum logic [2:0] {
      PS_ON = 3'h0,
      PS_STOPCLK = 3'h1,
      PS_POS = 3'h3,
      PS_STR = 3'h2,
      PS_STD = 3'h6
   } pmsu_pstate_e;

   typedef struct packed {
      logic power_button_n_smi_en;
      logic thermal_detect_n_en;
      logic alert_resume_en;
      logic alert_smi_en;
      logic alert_irq_en;
      logic lid_smi_en;
      logic ext_smi_en;
      logic battery_low_n_block_en;
   } pmsu_ctrl_s;

endpackage : pmsu_pkg

// ==== hdl/pmsu_top.sv ====
// Power management signal unit: suspend plane controls, clock stop requests and wake events.
// Assumes a free running clk, APB master on the same clock, event pins asynchronous to clk.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module pmsu_top #(
   parameter int unsigned DEBOUNCE_CYC = pmsu_pkg::DEBOUNCE_CYCLES,
   parameter int unsigned THR_UNIT_CYC = pmsu_pkg::THR_UNIT_CYCLES
) (
   // Clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic resume_reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pmsu_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event pins
   input wire logic battery_low_n,
   input wire logic ext_mgmt_irq_i,
   input wire logic lid_switch,
   input wire logic power_button_n,
   input wire logic ring_indicate_n,
   input wire logic sysbus_alert_n,
   input wire logic thermal_detect_n,
   input wire logic [3:0] pci_master_req_mon_n,
   // Serial interrupt block, same clock
   input wire logic serirq_smi_req,
   // Interrupt and event outputs
   output logic ext_mgmt_irq_o,
   output logic ext_mgmt_irq_oe,
   output logic sys_mgmt_irq_n,
   output logic sysbus_alert_irq,
   output logic resume_event,
   // Suspend and clock control pins
   output logic plane_a_suspend_n,
   output logic plane_b_suspend_n,
   output logic plane_c_suspend_n,
   output logic host_clk_suspend_status_n,
   output logic periph_suspend_status_n,
   output logic proc_clock_stop_n,
   output logic pci_clock_stop_n,
   output logic proc_stop_clock_req_n,
   output logic cache_sram_sleep
);
   import pmsu_pkg::*;

   localparam int DEB_W = $clog2(DEBOUNCE_CYC);
   localparam int UNIT_W = $clog2(THR_UNIT_CYC + 1);

   // Counters cannot serve shorter spans
   if (DEBOUNCE_CYC < 2 || THR_UNIT_CYC < 1) begin : g_bad_param
      $error("pmsu_top: debounce needs 2 cycles and throttle unit 1 cycle at least");
   end

   function automatic logic in_suspend(input pmsu_pstate_e s);
      in_suspend = (s == PS_POS) || (s == PS_STR) || (s == PS_STD);
   endfunction : in_suspend

   function automatic logic legal_state(input logic [2:0] v);
      legal_state = (v == PS_ON) || (v == PS_STOPCLK) || in_suspend(pmsu_pstate_e'(v));
   endfunction : legal_state

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         wmerge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
   endfunction : wmerge

   // Dedicated level when selected, general output otherwise
   function automatic logic pin_mux(input logic ded, input logic fn, input logic gp);
      pin_mux = ded ? fn : gp;
   endfunction : pin_mux

   // Synchronisers, suspend well
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [SYNC_W-1:0] sync_c;
   wire [SYNC_W-1:0] async_in = {pci_master_req_mon_n, thermal_detect_n, sysbus_alert_n, ring_indicate_n,
                                 power_button_n, lid_switch, ext_mgmt_irq_i, battery_low_n};

   always_ff @(posedge clk or negedge resume_reset_n) begin
      if (!resume_reset_n) begin
         sync_a <= '1;
         sync_b <= '1;
         sync_c <= '1;
      end else begin
         sync_a <= async_in;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Debounce: channel 0 lid, channel 1 power button
   logic [1:0] deb_stable;
   logic [1:0] deb_prev;
   logic [DEB_W-1:0] deb_cnt [2];

   for (genvar g = 0; g < 2; g++) begin : g_deb
      localparam int IDX = (g == 0) ? SY_LID : SY_PWR;
      wire raw = sync_b[IDX];
      wire restart = (raw == deb_stable[g]) || (raw != sync_c[IDX]);
      wire done = (deb_cnt[g] == DEB_W'(DEBOUNCE_CYC - 1));
      always_ff @(posedge clk or negedge resume_reset_n) begin
         if (!resume_reset_n) begin
            deb_stable[g] <= 1'b1;
            deb_prev[g] <= 1'b1;
            deb_cnt[g] <= '0;
         end else begin
            deb_prev[g] <= deb_stable[g];
            if (restart) begin
               deb_cnt[g] <= '0;
            end else if (done) begin
               deb_stable[g] <= raw;
               deb_cnt[g] <= '0;
            end else begin
               deb_cnt[g] <= deb_cnt[g] + 1'b1;
            end
         end
      end
   end

   // Core registers
   pmsu_ctrl_s ctrl;
   logic [FSEL_W-1:0] fsel;
   logic [GPO_W-1:0] general_output_pin;
   logic [7:0] thr_rate;
   logic [STS_W-1:0] status;
   pmsu_pstate_e pstate;
   pmsu_pstate_e next_pstate;

   // Event decode
   wire ext_fall = sync_c[SY_EXT] & ~sync_b[SY_EXT];
   wire lid_chg = fsel[FS_LID] & (deb_stable[0] != deb_prev[0]);
   wire pwr_press = deb_prev[1] & ~deb_stable[1];
   wire ri_fall = fsel[FS_RI] & sync_c[SY_RI] & ~sync_b[SY_RI];
   wire alert_act = fsel[FS_ALERT] & ~sync_b[SY_ALERT];
   wire pci_act = ~&sync_b[SY_REQ +: 4];
   wire battery_low_n_act = fsel[FS_BATTERY_LOW_N] & ~sync_b[SY_BATTERY_LOW_N];
   wire thermal_detect_n_act = fsel[FS_THERMAL_DETECT_N] & ctrl.thermal_detect_n_en & ~sync_b[SY_THERMAL_DETECT_N];
   wire wake = ri_fall | pwr_press | (alert_act & ctrl.alert_resume_en);
   wire resume_block = ctrl.battery_low_n_block_en & battery_low_n_act;
   wire resume_blocked = in_suspend(pstate) & wake & resume_block;
   wire resume_go = in_suspend(pstate) & wake & ~resume_block;

   // APB decode
   wire apb_setup = psel & ~penable;
   wire apb_xfer = psel & penable & pready;
   wire apb_wr = apb_xfer & pwrite;
   wire wr_ctrl = apb_wr & (paddr == REG_CTRL);
   wire wr_state = apb_wr & (paddr == REG_STATE) & pstrb[0] & legal_state(pwdata[2:0]);
   wire wr_fsel = apb_wr & (paddr == REG_FSEL);
   wire wr_gpo = apb_wr & (paddr == REG_GPO);
   wire wr_status = apb_wr & (paddr == REG_STATUS) & pstrb[0];
   wire wr_thr = apb_wr & (paddr == REG_THROTTLE);
   wire addr_ok = (paddr == REG_CTRL) | (paddr == REG_STATE) | (paddr == REG_FSEL) | (paddr == REG_GPO) |
                  (paddr == REG_GPI) | (paddr == REG_STATUS) | (paddr == REG_THROTTLE);
   wire [31:0] rd_ctrl = {24'h000000, ctrl};
   wire [31:0] rd_state = {29'h00000000, pstate};
   wire [31:0] rd_fsel = {20'h00000, fsel};
   wire [31:0] rd_gpo = {25'h0000000, general_output_pin};
   wire [31:0] rd_gpi = {19'h00000, deb_stable, sync_b};
   wire [31:0] rd_status = {21'h000000, thermal_detect_n_act, pstate, status};
   wire [31:0] rd_thr = {24'h000000, thr_rate};
   wire [31:0] rd_mux = (paddr == REG_CTRL) ? rd_ctrl :
                        (paddr == REG_STATE) ? rd_state :
                        (paddr == REG_FSEL) ? rd_fsel :
                        (paddr == REG_GPO) ? rd_gpo :
                        (paddr == REG_GPI) ? rd_gpi :
                        (paddr == REG_STATUS) ? rd_status :
                        (paddr == REG_THROTTLE) ? rd_thr : 32'h00000000;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         // One wait state so read data is a flop
         pready <= psel & penable & ~pready;
         if (apb_setup) begin
            prdata <= rd_mux;
            pslverr <= ~addr_ok;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= pmsu_ctrl_s'(CTRL_RST);
         fsel <= FSEL_RST;
         general_output_pin <= GPO_RST;
         thr_rate <= THR_RST;
      end else begin
         if (wr_ctrl) ctrl <= pmsu_ctrl_s'(8'(wmerge(rd_ctrl, pwdata, pstrb)));
         if (wr_fsel) fsel <= FSEL_W'(wmerge(rd_fsel, pwdata, pstrb));
         if (wr_gpo) general_output_pin <= GPO_W'(wmerge(rd_gpo, pwdata, pstrb));
         if (wr_thr) thr_rate <= 8'(wmerge(rd_thr, pwdata, pstrb));
      end
   end

   // Sticky status, set beats write-one-to-clear
   wire [STS_W-1:0] sts_set = {pci_act, resume_blocked, ri_fall, pwr_press, alert_act, lid_chg, ext_fall};
   wire [STS_W-1:0] sts_clr = wr_status ? pwdata[STS_W-1:0] : '0;

   // Power state: software request first, then wake, then bus activity
   assign next_pstate = wr_state ? pmsu_pstate_e'(pwdata[2:0]) :
                        resume_go ? PS_ON :
                        ((pstate == PS_STOPCLK) && pci_act) ? PS_ON : pstate;

   always_ff @(posedge clk or negedge resume_reset_n) begin
      if (!resume_reset_n) begin
         status <= '0;
         pstate <= PS_ON;
      end else begin
         status <= (status & ~sts_clr) | sts_set;
         pstate <= next_pstate;
      end
   end

   // Suspend well outputs, low while in resume reset
   always_ff @(posedge clk or negedge resume_reset_n) begin
      if (!resume_reset_n) begin
         plane_a_suspend_n <= 1'b0;
         plane_b_suspend_n <= 1'b0;
         plane_c_suspend_n <= 1'b0;
         host_clk_suspend_status_n <= 1'b0;
         periph_suspend_status_n <= 1'b0;
      end else begin
         plane_a_suspend_n <= ~in_suspend(pstate);
         plane_b_suspend_n <= pin_mux(fsel[FS_OUT_BASE + GO_PLANE_B_SUSPEND_N], ~((pstate == PS_STR) || (pstate == PS_STD)),
                                      general_output_pin[GO_PLANE_B_SUSPEND_N]);
         plane_c_suspend_n <= pin_mux(fsel[FS_OUT_BASE + GO_PLANE_C_SUSPEND_N], pstate != PS_STD, general_output_pin[GO_PLANE_C_SUSPEND_N]);
         host_clk_suspend_status_n <= pin_mux(fsel[FS_OUT_BASE + GO_STAT1], pstate == PS_ON,
                                              general_output_pin[GO_STAT1]);
         periph_suspend_status_n <= pin_mux(fsel[FS_OUT_BASE + GO_STAT2], ~in_suspend(pstate),
                                            general_output_pin[GO_STAT2]);
      end
   end

   // Throttle timer
   logic [UNIT_W-1:0] thr_pre;
   logic [7:0] thr_cnt;
   logic thr_phase;
   wire unit_tick = (thr_pre == UNIT_W'(THR_UNIT_CYC - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         thr_pre <= '0;
         thr_cnt <= 8'h00;
         thr_phase <= 1'b0;
      end else if (!thermal_detect_n_act) begin
         thr_pre <= '0;
         thr_cnt <= 8'h00;
         thr_phase <= 1'b0;
      end else if (unit_tick) begin
         thr_pre <= '0;
         thr_cnt <= (thr_cnt == thr_rate) ? 8'h00 : thr_cnt + 8'h01;
         if (thr_cnt == thr_rate) thr_phase <= ~thr_phase;
      end else begin
         thr_pre <= thr_pre + 1'b1;
      end
   end

   // Core well outputs
   wire smi_any = (status[ST_EXT] & ctrl.ext_smi_en) | (status[ST_LID] & ctrl.lid_smi_en) |
                  (status[ST_ALERT] & ctrl.alert_smi_en) | (status[ST_PWR] & ctrl.power_button_n_smi_en);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sys_mgmt_irq_n <= 1'b1;
         sysbus_alert_irq <= 1'b0;
         resume_event <= 1'b0;
         ext_mgmt_irq_o <= 1'b0;
         ext_mgmt_irq_oe <= 1'b0;
         proc_clock_stop_n <= 1'b1;
         pci_clock_stop_n <= 1'b1;
         proc_stop_clock_req_n <= 1'b1;
         cache_sram_sleep <= 1'b0;
      end else begin
         sys_mgmt_irq_n <= ~smi_any;
         sysbus_alert_irq <= status[ST_ALERT] & ctrl.alert_irq_en;
         resume_event <= resume_go;
         // Open drain: output stays low, only the enable moves
         ext_mgmt_irq_o <= 1'b0;
         ext_mgmt_irq_oe <= serirq_smi_req;
         proc_clock_stop_n <= pin_mux(fsel[FS_OUT_BASE + GO_CPU], pstate == PS_ON, general_output_pin[GO_CPU]);
         pci_clock_stop_n <= pin_mux(fsel[FS_OUT_BASE + GO_PCI], ~in_suspend(pstate), general_output_pin[GO_PCI]);
         proc_stop_clock_req_n <= ~((pstate != PS_ON) | (thermal_detect_n_act & thr_phase));
         cache_sram_sleep <= pin_mux(fsel[FS_OUT_BASE + GO_ZZ], pstate == PS_STOPCLK, general_output_pin[GO_ZZ]);
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !resume_reset_n);

   property p_battery_low_n_block;
      resume_blocked && !wr_state |=> pstate == $past(pstate);
   endproperty
   a_battery_low_n_block: assert property (p_battery_low_n_block) else $error("resume taken under battery low");

   property p_cpu_stop;
      (pstate == PS_STOPCLK) && fsel[FS_OUT_BASE + GO_CPU] |=> !proc_clock_stop_n;
   endproperty
   a_cpu_stop: assert property (p_cpu_stop) else $error("processor clock stop not low");

   property p_ext_smi;
      ext_fall && ctrl.ext_smi_en && !sts_clr[ST_EXT] |=> status[ST_EXT] ##1 (!sys_mgmt_irq_n || !ctrl.ext_smi_en);
   endproperty
   a_ext_smi: assert property (p_ext_smi) else $error("external edge gave no management interrupt");

   property p_serirq_drive;
      serirq_smi_req |=> ext_mgmt_irq_oe && !ext_mgmt_irq_o;
   endproperty
   a_serirq_drive: assert property (p_serirq_drive) else $error("management pin not driven low");

   property p_lid_edge;
      lid_chg |=> status[ST_LID];
   endproperty
   a_lid_edge: assert property (p_lid_edge) else $error("lid change not recorded");

   property p_debounce;
      $changed(deb_stable[0]) |-> $past(deb_cnt[0]) == DEB_W'(DEBOUNCE_CYC - 1);
   endproperty
   a_debounce: assert property (p_debounce) else $error("lid level taken before debounce ended");

   property p_plane_a;
      in_suspend(pstate) |=> !plane_a_suspend_n;
   endproperty
   a_plane_a: assert property (p_plane_a) else $error("plane A not asserted in suspend");

   property p_plane_b_pos;
      (pstate == PS_POS) && fsel[FS_OUT_BASE + GO_PLANE_B_SUSPEND_N] |=> plane_b_suspend_n;
   endproperty
   a_plane_b_pos: assert property (p_plane_b_pos) else $error("plane B asserted in power on suspend");

   property p_plane_c;
      resume_reset_n && fsel[FS_OUT_BASE + GO_PLANE_C_SUSPEND_N] |=> (plane_c_suspend_n == ($past(pstate) != PS_STD));
   endproperty
   a_plane_c: assert property (p_plane_c) else $error("plane C wrong for state");

   property p_throttle;
      thermal_detect_n_act && thr_phase |=> !proc_stop_clock_req_n;
   endproperty
   a_throttle: assert property (p_throttle) else $error("stop clock request missing in throttle");

   property p_cache_sleep;
      cache_sram_sleep && $past(fsel[FS_OUT_BASE + GO_ZZ]) |-> $past(pstate) == PS_STOPCLK;
   endproperty
   a_cache_sleep: assert property (p_cache_sleep) else $error("cache sleep outside stop clock");

   c_enter_std: cover property ((pstate == PS_ON) ##1 (pstate == PS_STD));
   c_ext_smi: cover property (ext_fall ##2 !sys_mgmt_irq_n);
   c_throttle: cover property (thermal_detect_n_act && thr_phase ##1 !thr_phase);
   c_blocked: cover property (resume_blocked);

endmodule : pmsu_top

// ==== verification/pmsu_event_src.sv ====
// External agent on the open-drain management interrupt line.
// Assumes a pull-up on the line; the device sinks it through its enable.
`timescale 1ns/10ps
module pmsu_event_src (
   // Clock
   input wire logic clk,
   // Bench control
   input wire logic fire,
   input wire logic [3:0] low_len,
   // Device side of the pin
   input wire logic dev_oe,
   output logic pin_level
);
   logic [3:0] low_cnt = 4'h0;
   logic [2:0] gap_cnt = 3'h0;
   logic drive_low;
   assign drive_low = (low_cnt != 4'h0);
   // Pull-up wins unless somebody sinks the line
   assign pin_level = !(drive_low || dev_oe);
   always @(posedge clk) begin
      if (drive_low) begin
         low_cnt <= low_cnt - 4'h1;
         gap_cnt <= 3'h4;
      end else if (gap_cnt != 3'h0) begin
         gap_cnt <= gap_cnt - 3'h1;
      end else if (fire) begin
         low_cnt <= (low_len == 4'h0) ? 4'h1 : low_len;
      end
   end
endmodule : pmsu_event_src

// ==== verification/power_mgmt_signal_unit_test.sv ====
// Self-checking bench for the power management signal unit.
// Assumes shortened debounce and throttle units passed as top parameters.
`timescale 1ns/10ps
module power_mgmt_signal_unit_test;
   import pmsu_pkg::*;
   localparam int DEB = 8;
   logic clk, sys_rst, resume_reset_n, psel, penable, pwrite, pready, pslverr, re;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rq, r;
   logic battery_low_n, lid_switch, power_button_n, ring_indicate_n, sysbus_alert_n, thermal_detect_n;
   logic [3:0] pci_master_req_mon_n, low_len;
   logic serirq_smi_req, ext_pin, ext_o, ext_oe, fire, sys_mgmt_irq_n, sysbus_alert_irq, resume_event;
   logic plane_a_suspend_n, plane_b_suspend_n, plane_c_suspend_n, host_clk_suspend_status_n;
   logic periph_suspend_status_n, proc_clock_stop_n, pci_clock_stop_n, proc_stop_clock_req_n, cache_sram_sleep;
   logic [6:0] f, g;
   logic prev;
   logic [2:0] codes [5] = '{PS_ON, PS_STOPCLK, PS_POS, PS_STR, PS_STD};
   int bad_count = 0;
   int n_checks = 0;
   int seed = 46501;
   int cnt;
   wire [7:0] pins = {plane_a_suspend_n, plane_b_suspend_n, plane_c_suspend_n, host_clk_suspend_status_n,
      periph_suspend_status_n, proc_clock_stop_n, pci_clock_stop_n, proc_stop_clock_req_n};
   wire [6:0] gpins = {periph_suspend_status_n, host_clk_suspend_status_n, cache_sram_sleep, pci_clock_stop_n,
      proc_clock_stop_n, plane_c_suspend_n, plane_b_suspend_n};

   pmsu_top #(.DEBOUNCE_CYC(DEB), .THR_UNIT_CYC(2)) pmsu_top_inst (.clk, .sys_rst, .resume_reset_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .battery_low_n,
      .ext_mgmt_irq_i(ext_pin), .lid_switch, .power_button_n, .ring_indicate_n, .sysbus_alert_n,
      .thermal_detect_n, .pci_master_req_mon_n, .serirq_smi_req, .ext_mgmt_irq_o(ext_o),
      .ext_mgmt_irq_oe(ext_oe), .sys_mgmt_irq_n, .sysbus_alert_irq, .resume_event, .plane_a_suspend_n,
      .plane_b_suspend_n, .plane_c_suspend_n, .host_clk_suspend_status_n, .periph_suspend_status_n,
      .proc_clock_stop_n, .pci_clock_stop_n, .proc_stop_clock_req_n, .cache_sram_sleep);
   pmsu_event_src pmsu_event_src_inst (.clk, .fire, .low_len, .dev_oe(ext_oe), .pin_level(ext_pin));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [7:0] exp_pins(input logic [2:0] s);
      logic on, sus;
      on = (s == PS_ON);
      sus = (s == PS_POS) || (s == PS_STR) || (s == PS_STD);
      return {!sus, !(s == PS_STR || s == PS_STD), s != PS_STD, on, !sus, on, !sus, on};
   endfunction : exp_pins

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] gt);
      n_checks++;
      if (gt !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, gt);
      end
   endtask : chk

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask : ticks

   // Master never assumes the wait count; only the watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wait_lvl(ref logic s, input logic v, input int lim, input string nm);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk(nm, v, s);
   endtask : wait_lvl

   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask : done

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end

   initial begin
      {sys_rst, resume_reset_n, psel, penable, pwrite, paddr, pwdata} = {2'b10, 3'b0, 8'h00, 32'h0};
      {battery_low_n, lid_switch, power_button_n, ring_indicate_n, sysbus_alert_n, thermal_detect_n} = 6'h3F;
      {pci_master_req_mon_n, serirq_smi_req, fire, low_len} = {4'hF, 2'b0, 4'h1};
      ticks(10);
      sys_rst <= 1'b0;
      resume_reset_n <= 1'b1;
      ticks(2);
      chk("pins", 8'hFF, pins);
      chk("sleep", 0, cache_sram_sleep);
      bus(1'b0, REG_FSEL, 0);
      chk("fsel", 32'hFFF, rq);
      bus(1'b0, 8'h1C, 0);
      chk("unmapped", 1, re);
      done("reset");
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, REG_STATE, {29'h0, codes[i]});
         ticks(2);
         chk("pins", exp_pins(codes[i]), pins);
         if (i < 3) chk("sleep", i == 1, cache_sram_sleep);
         bus(1'b0, REG_STATE, 0);
         chk("state", codes[i], rq[2:0]);
      end
      bus(1'b1, REG_STATE, 0);
      done("states");
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         f = (i == 0) ? 7'h0 : r[6:0];
         g = r[13:7];
         bus(1'b1, REG_FSEL, {20'h0, f, 5'h1F});
         bus(1'b1, REG_GPO, {25'h0, g});
         ticks(2);
         chk("gpo", (f & 7'h6F) | (~f & g), gpins);
      end
      bus(1'b1, REG_FSEL, 32'hFFF);
      done("gpo");
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, REG_STATUS, 32'h7F);
         bus(1'b1, REG_CTRL, i ? 32'h02 : 32'h00);
         fire <= 1'b1;
         @(posedge clk);
         fire <= 1'b0;
         ticks(1);
         chk("smi early", 1, sys_mgmt_irq_n);
         wait_lvl(sys_mgmt_irq_n, !i, 10, "smi ext");
         ticks(6);
      end
      bus(1'b1, REG_STATUS, 32'h7F);
      wait_lvl(sys_mgmt_irq_n, 1'b1, 4, "smi clear");
      serirq_smi_req <= 1'b1;
      wait_lvl(ext_oe, 1'b1, 4, "ext oe");
      chk("ext o", 0, ext_o);
      serirq_smi_req <= 1'b0;
      ticks(8);
      done("ext");
      bus(1'b1, REG_CTRL, 32'h04);
      bus(1'b1, REG_STATUS, 32'h7F);
      lid_switch <= 1'b0;
      ticks(DEB / 2);
      lid_switch <= 1'b1;
      ticks(DEB + 6);
      chk("lid glitch", 1, sys_mgmt_irq_n);
      for (int i = 0; i < 2; i++) begin
         lid_switch <= i[0];
         ticks(DEB - 2);
         chk("lid early", 1, sys_mgmt_irq_n);
         wait_lvl(sys_mgmt_irq_n, 1'b0, 10, "lid smi");
         bus(1'b1, REG_STATUS, 32'h7F);
      end
      done("lid");
      bus(1'b1, REG_CTRL, 32'h01);
      battery_low_n <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, REG_STATE, {29'h0, PS_STR});
         power_button_n <= 1'b0;
         ticks(DEB + 8);
         power_button_n <= 1'b1;
         ticks(DEB + 8);
         bus(1'b0, REG_STATUS, 0);
         chk("wake", i ? PS_ON : PS_STR, rq[9:7]);
         chk("blocked", !i, rq[ST_BLOCKED]);
         battery_low_n <= 1'b1;
         bus(1'b1, REG_STATUS, 32'h7F);
      end
      done("button");
      bus(1'b1, REG_STATE, {29'h0, PS_STD});
      ring_indicate_n <= 1'b0;
      ticks(4);
      ring_indicate_n <= 1'b1;
      bus(1'b0, REG_STATUS, 0);
      chk("ring wake", {PS_ON, 1'b1}, {rq[9:7], rq[ST_RI]});
      bus(1'b1, REG_STATUS, 32'h7F);
      done("ring");
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, REG_CTRL, 32'h08 << i);
         if (i == 2) bus(1'b1, REG_STATE, {29'h0, PS_POS});
         sysbus_alert_n <= 1'b0;
         if (i == 2) wait_lvl(resume_event, 1'b1, 10, "alert resume");
         ticks(6);
         chk("alert irq", i == 0, sysbus_alert_irq);
         chk("alert smi", i != 1, sys_mgmt_irq_n);
         sysbus_alert_n <= 1'b1;
         ticks(4);
         bus(1'b1, REG_STATUS, 32'h7F);
      end
      bus(1'b0, REG_STATE, 0);
      chk("resumed", PS_ON, rq[2:0]);
      done("alert");
      bus(1'b1, REG_CTRL, 32'h40);
      bus(1'b1, REG_THROTTLE, 32'h01);
      thermal_detect_n <= 1'b0;
      ticks(8);
      cnt = 0;
      prev = proc_stop_clock_req_n;
      repeat (40) begin
         @(posedge clk);
         cnt += (proc_stop_clock_req_n !== prev);
         prev = proc_stop_clock_req_n;
      end
      chk("toggles", 1, cnt >= 9 && cnt <= 11);
      thermal_detect_n <= 1'b1;
      ticks(12);
      chk("throttle off", 1, proc_stop_clock_req_n);
      done("thermal");
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, REG_STATE, {29'h0, PS_STOPCLK});
         pci_master_req_mon_n <= ~(4'h1 << k);
         ticks(8);
         pci_master_req_mon_n <= 4'hF;
         bus(1'b0, REG_STATE, 0);
         chk("pci wake", PS_ON, rq[2:0]);
      end
      done("pci");
      bus(1'b1, REG_STATE, {29'h0, PS_STR});
      resume_reset_n <= 1'b0;
      ticks(2);
      chk("well reset", 5'h00, pins[7:3]);
      resume_reset_n <= 1'b1;
      ticks(2);
      chk("well out", 8'hFF, pins);
      bus(1'b0, REG_STATE, 0);
      chk("well state", PS_ON, rq[2:0]);
      done("resume reset");
      complete_run();
   end
endmodule : power_mgmt_signal_unit_test
